/* File: verilog/pief_top.sv */
// Peripheral event flag register with AHB-Lite slave and interrupt.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
module pief_top (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic OSC_FAIL_I,
	input wire logic COMPARATOR_B_OUTPUT_I,
	input wire logic COMPARATOR_A_OUTPUT_I,
	input wire logic SEGMENT_DISPLAY_EVT_I,
	input wire logic LOW_VOLTAGE_EVT_I,
	input wire logic CAPCOMP_B_EVT_I,
	output logic USE_INTERNAL_OSC_O,
	output logic IRQ_O
);
	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] mask;
		logic osc_sel;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} pief_state_type;
	pief_state_type st_r;
	pief_state_type st_nxt;

	logic cmpb_change;
	logic cmpa_change;
	logic [7:0] events;
	logic [7:0] w1c;
	logic take;
	logic [7:0] addr8;

	// Comparator outputs are levels; only a change raises the flag.
	pief_edge u_cmpb (
		.clk_i(CLK_SYS_I),
		.rstn_i(RSTN_I),
		.level_i(COMPARATOR_B_OUTPUT_I),
		.change_o(cmpb_change)
	);
	pief_edge u_cmpa (
		.clk_i(CLK_SYS_I),
		.rstn_i(RSTN_I),
		.level_i(COMPARATOR_A_OUTPUT_I),
		.change_o(cmpa_change)
	);

	// Event vector; unimplemented bits stay zero.
	always_comb begin
		events = 8'h00;
		events[pief_pkg::PIEF_OSC_BIT] = OSC_FAIL_I & ~st_r.osc_sel; // R5
		events[pief_pkg::PIEF_CMPB_BIT] = cmpb_change; // R6
		events[pief_pkg::PIEF_CMPA_BIT] = cmpa_change; // R7
		events[pief_pkg::PIEF_LCD_BIT] = SEGMENT_DISPLAY_EVT_I; // R7
		events[pief_pkg::PIEF_LVD_BIT] = LOW_VOLTAGE_EVT_I; // R7
		events[pief_pkg::PIEF_CCP_BIT] = CAPCOMP_B_EVT_I; // R7
	end

	// ----------------------------------------------------------------
	// Bus decode and register update.
	// ----------------------------------------------------------------
	assign take = HSEL_I & HREADY_I & HTRANS_I[1];
	// Each register takes one aligned word, so the word index is decoded.
	assign addr8 = HADDR_I[9:2];

	// Writes land one cycle after the address phase, so the slave
	// never stalls. Set beats clear, so a same-cycle event survives.
	always_comb begin
		st_nxt = st_r;
		w1c = 8'h00;
		if (st_r.wr_pend) begin
			unique case (st_r.wr_addr)
				pief_pkg::PIEF_FLAGS_OFS: w1c = HWDATA_I[7:0];
				pief_pkg::PIEF_MASK_OFS:
					st_nxt.mask = HWDATA_I[7:0] & pief_pkg::PIEF_IMPL_MASK;
				pief_pkg::PIEF_CTRL_OFS:
					st_nxt.osc_sel = st_r.osc_sel &
						HWDATA_I[pief_pkg::PIEF_CTRL_SEL_BIT];
				default: ;
			endcase
		end
		// Events set flags whatever the mask holds.
		st_nxt.flags = ((st_r.flags & ~w1c) | events) &
			pief_pkg::PIEF_IMPL_MASK; // R2
		// Failure forces the internal oscillator; software may only
		// return to the main oscillator by writing zero.
		if (OSC_FAIL_I) begin
			st_nxt.osc_sel = 1'b1; // R4
		end
		st_nxt.wr_pend = take & HWRITE_I;
		st_nxt.wr_addr = addr8;
		st_nxt.rdata = 32'h0000_0000;
		if (take && !HWRITE_I) begin
			unique case (addr8)
				pief_pkg::PIEF_FLAGS_OFS: st_nxt.rdata[7:0] = st_r.flags; // R1
				pief_pkg::PIEF_MASK_OFS: st_nxt.rdata[7:0] = st_r.mask;
				pief_pkg::PIEF_CTRL_OFS:
					st_nxt.rdata[pief_pkg::PIEF_CTRL_SEL_BIT] = st_r.osc_sel;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_r.flags <= pief_pkg::PIEF_FLAGS_RST; // R7
			st_r.mask <= pief_pkg::PIEF_MASK_RST;
			st_r.osc_sel <= 1'b0;
			st_r.wr_pend <= 1'b0;
			st_r.wr_addr <= 8'h00;
			st_r.rdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs.
	assign HRDATA_O = st_r.rdata;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign USE_INTERNAL_OSC_O = st_r.osc_sel;
	assign IRQ_O = |(st_r.flags & st_r.mask);

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence s_flag_write;
		st_r.wr_pend && st_r.wr_addr == pief_pkg::PIEF_FLAGS_OFS;
	endsequence

	chk_event_sets_flag: assert property (@(posedge CLK_SYS_I) // R2
		disable iff (!RSTN_I) LOW_VOLTAGE_EVT_I |=> st_r.flags[2])
		else $error("Low voltage event did not set flag.");
	chk_osc_switch: assert property (@(posedge CLK_SYS_I) // R4
		disable iff (!RSTN_I) OSC_FAIL_I |=> USE_INTERNAL_OSC_O)
		else $error("Oscillator failure did not switch clock.");
	chk_osc_flag_sticky: assert property (@(posedge CLK_SYS_I) // R5
		disable iff (!RSTN_I) st_r.flags[7] && !st_r.wr_pend
		|=> st_r.flags[7])
		else $error("Oscillator flag dropped without a clear.");
	chk_cmpb_change: assert property (@(posedge CLK_SYS_I) // R6
		disable iff (!RSTN_I)
		$changed(COMPARATOR_B_OUTPUT_I) ##1 1'b1 |=> st_r.flags[6])
		else $error("Comparator B change not flagged.");
	chk_unimpl_zero: assert property (@(posedge CLK_SYS_I) // R7
		disable iff (!RSTN_I) st_r.flags[3] == 1'b0 &&
		st_r.flags[1] == 1'b0)
		else $error("Unimplemented flag bit set.");
	chk_clear_write: assert property (@(posedge CLK_SYS_I) // R1
		disable iff (!RSTN_I) s_flag_write ##0 HWDATA_I[4]
		&& !SEGMENT_DISPLAY_EVT_I |=> !st_r.flags[4])
		else $error("Write one did not clear flag.");
	chk_irq_level: assert property (@(posedge CLK_SYS_I)
		disable iff (!RSTN_I)
		IRQ_O == |(st_r.flags & st_r.mask))
		else $error("Interrupt output wrong.");
	chk_read_flags: assert property (@(posedge CLK_SYS_I) // R1
		disable iff (!RSTN_I) take && !HWRITE_I &&
		addr8 == pief_pkg::PIEF_FLAGS_OFS && w1c == 8'h00
		|=> HRDATA_O[7:0] == $past(st_r.flags))
		else $error("Flag read returned wrong data.");
endmodule : pief_top

/* File: verilog/pief_pkg.sv */
// Constants for the peripheral event flag register block.
//
// Contract
// R1: Flag register at data address 0x0D.
// R2: Flags set regardless of any enable bit.
// R3: Software clears flags before enabling interrupts.
// R4: Oscillator failure switches clock to internal oscillator.
// R5: Bit 7 oscillator failure flag, sticky.
// R6: Bit 6 comparator B change, sticky.
// R7: Bits 5,4,2,0 events; 3,1 zero; reset zero.
package pief_pkg;
	// ----------------------------------------------------------------
	// Register map. Offsets are word indices; the byte address on the
	// bus is four times the index, since the flag offset is not aligned.
	// ----------------------------------------------------------------
	localparam logic [7:0] PIEF_FLAGS_OFS = 8'h0D;
	localparam logic [7:0] PIEF_MASK_OFS = 8'h10;
	localparam logic [7:0] PIEF_CTRL_OFS = 8'h14;
	localparam logic [7:0] PIEF_FLAGS_RST = 8'h00;
	localparam logic [7:0] PIEF_MASK_RST = 8'h00;
	localparam logic [7:0] PIEF_IMPL_MASK = 8'hF5;
	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int PIEF_OSC_BIT = 7;
	localparam int PIEF_CMPB_BIT = 6;
	localparam int PIEF_CMPA_BIT = 5;
	localparam int PIEF_LCD_BIT = 4;
	localparam int PIEF_LVD_BIT = 2;
	localparam int PIEF_CCP_BIT = 0;
	localparam int PIEF_CTRL_SEL_BIT = 0;
endpackage : pief_pkg

/* File: verilog/pief_edge.sv */
// Change detector for one comparator output.
`timescale 1ns/100ps
module pief_edge (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic level_i,
	output logic change_o
);
	typedef struct packed {
		logic prev;
		logic armed;
	} pief_edge_type;
	pief_edge_type st_r;
	pief_edge_type st_nxt;

	// The first sample after reset only arms, so a start-up level is
	// not reported as a change.
	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = level_i;
		st_nxt.armed = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign change_o = st_r.armed & (st_r.prev != level_i);
endmodule : pief_edge

/* File: testbench/pief_top_tb.sv */
// Self-checking bench for the peripheral event flag register block.
`timescale 1ns/100ps
module pief_top_tb;
	logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, wr = 1'b0, hready;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, rd;
	logic [1:0] trans = 2'h0;
	logic osc = 1'b0, cmpb = 1'b0, cmpa = 1'b0, lcd = 1'b0, lvd = 1'b0;
	logic ccp = 1'b0, irq, int_osc, resp;
	logic [7:0] acc, msk, clr;
	logic [31:0] seed = 32'hC956C1AD;
	int n_errors = 0, compares = 0, cycles = 0;
	pief_top pief_top_i (.CLK_SYS_I(clk), .RSTN_I(rstn), .HSEL_I(sel),
		.HADDR_I(addr), .HTRANS_I(trans), .HWRITE_I(wr), .HSIZE_I(3'h2),
		.HWDATA_I(wdata), .HREADY_I(hready), .HRDATA_O(rdata),
		.HREADYOUT_O(hready), .HRESP_O(resp), .OSC_FAIL_I(osc),
		.COMPARATOR_B_OUTPUT_I(cmpb), .COMPARATOR_A_OUTPUT_I(cmpa),
		.SEGMENT_DISPLAY_EVT_I(lcd), .LOW_VOLTAGE_EVT_I(lvd),
		.CAPCOMP_B_EVT_I(ccp), .USE_INTERNAL_OSC_O(int_osc), .IRQ_O(irq));
	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	// Repeatable pseudo-random source.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Flag image of one event vector; bits 7, 3 and 1 never set here.
	function automatic logic [7:0] exp_flags(input logic [4:0] e);
		return {1'b0, e[4], e[3], e[2], 1'b0, e[1], 1'b0, e[0]};
	endfunction : exp_flags
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One single AHB transfer; waits on hready rather than assuming latency.
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		sel <= 1'b1; trans <= 2'h2; wr <= w; addr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		sel <= 1'b0; trans <= 2'h0; wdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = rdata;
		#1;
	endtask : xfer
	// Comparators toggle, pulsed events stand for one cycle.
	task automatic fire(input logic [4:0] e);
		@(posedge clk);
		cmpb <= cmpb ^ e[4]; cmpa <= cmpa ^ e[3];
		lcd <= e[2]; lvd <= e[1]; ccp <= e[0];
		@(posedge clk);
		lcd <= 1'b0; lvd <= 1'b0; ccp <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : fire
	task automatic results();
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	// ----------------------------------------------------------------
	// Clock, reset and hang guard.
	// ----------------------------------------------------------------
	initial begin
		forever #2 clk = ~clk;
	end
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		xfer(1'b0, 32'h34, 32'h0, rd); chk(rd, 32'h0);
		xfer(1'b0, 32'h40, 32'h0, rd); chk(rd, 32'h0);
		xfer(1'b0, 32'h20, 32'h0, rd); chk(rd, 32'h0);
		chk({resp, irq, int_osc}, 32'h0);
		acc = 8'h00;
		// Every event but oscillator failure alone first, then random mixes; the mask varies too.
		for (int i = 0; i < 30; i++) begin
			msk = (i < 5) ? 8'h00 : rnd();
			xfer(1'b1, 32'h40, {24'h0, msk}, rd);
			xfer(1'b0, 32'h40, 32'h0, rd); chk(rd, {24'h0, msk & 8'hF5});
			fire((i < 5) ? 5'h01 << i : rnd());
			acc = acc | exp_flags(i < 5 ? 5'h01 << i : seed[4:0]);
			xfer(1'b0, 32'h34, 32'h0, rd); chk(rd, {24'h0, acc});
			chk(irq, |(acc & msk & 8'hF5));
			clr = rnd();
			xfer(1'b1, 32'h34, {24'h0, clr}, rd);
			acc = acc & ~clr;
			chk(irq, |(acc & msk & 8'hF5));
		end
		// Oscillator failure, a clear while it persists, then recovery.
		@(posedge clk);
		osc <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(int_osc, 1'b1);
		xfer(1'b0, 32'h34, 32'h0, rd); chk(rd[7], 1'b1);
		xfer(1'b1, 32'h34, 32'hFF, rd);
		repeat (3) @(posedge clk);
		xfer(1'b0, 32'h34, 32'h0, rd); chk(rd, 32'h0);
		xfer(1'b0, 32'h50, 32'h0, rd); chk(rd, 32'h1);
		@(posedge clk);
		osc <= 1'b0;
		xfer(1'b1, 32'h50, 32'h0, rd);
		xfer(1'b0, 32'h50, 32'h0, rd); chk(rd, 32'h0);
		chk(int_osc, 1'b0);
		results();
	end
endmodule : pief_top_tb
